// >>> rtl/ufm_device.sv
// USB function end: command decoder, endpoint buffers, interrupt and
// suspend pins. Assumes the protocol engine delivers packet bytes on the
// user side and that the core clock is four times the bus bit rate.
`timescale 1ns/10ps
module ufm_device (
    input wire logic core_clk_i,
    input wire logic reset_i,
    ufm_if.dev pins,
    input wire logic line_i,
    input wire logic rx_valid_i,
    input wire logic [2:0] rx_ep_i,
    input wire logic [7:0] rx_data_i,
    input wire logic rx_end_i,
    input wire logic tx_next_i,
    input wire logic [2:0] tx_ep_i,
    input wire logic tx_end_i,
    input wire logic bus_suspend_i,
    output logic [7:0] tx_data_o,
    output logic rx_bit_o,
    output logic rx_bit_valid_o,
    output logic wake_req_o,
    output logic dp_pullup_o,
    output logic pullup_drive_pin_o,
    output logic [6:0] usb_addr_o,
    output logic addr_en_o,
    output logic [5:0] ep_full_o,
    output logic [5:0] ep_stall_o
);

    // ----------------------------------------
    // Reset and port synchronisers
    // ----------------------------------------
    logic usb_rst;
    assign usb_rst = reset_i || !pins.iface_reset_n;

    logic [2:0] sel_s, cnd_s, wr_s, rd_s;
    always_ff @(posedge core_clk_i) begin
        if (usb_rst) begin
            sel_s <= 3'h0;
            cnd_s <= 3'h0;
            wr_s <= 3'h0;
            rd_s <= 3'h0;
        end else begin
            sel_s <= {sel_s[1:0], pins.interface_select};
            cnd_s <= {cnd_s[1:0], pins.command_not_data};
            wr_s <= {wr_s[1:0], pins.write_strobe};
            rd_s <= {rd_s[1:0], pins.read_strobe};
        end
    end

    logic wr_evt, rd_evt, cmd_wr, dat_wr, dat_rd;
    assign wr_evt = sel_s[1] && wr_s[1] && !wr_s[2];
    assign rd_evt = sel_s[1] && rd_s[1] && !rd_s[2];
    assign cmd_wr = wr_evt && cnd_s[1];
    assign dat_wr = wr_evt && !cnd_s[1];
    assign dat_rd = rd_evt && !cnd_s[1];

    // ----------------------------------------
    // Command state
    // ----------------------------------------
    logic [7:0] cmd_reg;
    logic [2:0] sel_ep_reg;
    logic [5:0] idx_reg;
    logic ep_en_reg;
    logic [7:0] md;
    logic [5:0] buf_ofs;
    assign md = pins.mcu_data;
    assign buf_ofs = idx_reg - ufm_pkg::BUF_HDR_BYTES;

    always_ff @(posedge core_clk_i) begin
        if (usb_rst) begin
            cmd_reg <= 8'h00;
            sel_ep_reg <= 3'h0;
            idx_reg <= 6'h00;
        end else if (cmd_wr) begin
            cmd_reg <= md;
            idx_reg <= 6'h00;
            if ((md & ufm_pkg::CMD_GROUP_MASK) == 8'h00 ||
                (md & ufm_pkg::CMD_GROUP_MASK) == ufm_pkg::CMD_SEL_CLR) begin
                sel_ep_reg <= md[2:0];
            end
        end else if ((dat_wr || dat_rd) && cmd_reg == ufm_pkg::CMD_BUFFER) begin
            idx_reg <= idx_reg + 6'h01;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (usb_rst) begin
            usb_addr_o <= 7'h00;
            addr_en_o <= 1'b0;
            ep_en_reg <= 1'b0;
            ep_stall_o <= 6'h00;
        end else if (dat_wr) begin
            if (cmd_reg == ufm_pkg::CMD_SET_ADDR) begin
                usb_addr_o <= md[6:0];
                addr_en_o <= md[7];
            end
            if (cmd_reg == ufm_pkg::CMD_SET_EP_EN) begin
                ep_en_reg <= md[0];
            end
            if ((cmd_reg & ufm_pkg::CMD_GROUP_MASK) == ufm_pkg::CMD_SEL_CLR) begin
                ep_stall_o[sel_ep_reg] <= md[0];
            end
        end
    end

    // Control endpoints ignore the enable bit
    function automatic logic ep_on(input logic [2:0] ep, input logic en);
        ep_on = (ep < ufm_pkg::FIRST_GATED_EP) || en;
    endfunction

    // ----------------------------------------
    // Endpoint buffer memory and pointers
    // ----------------------------------------
    logic [7:0] mem [0:ufm_pkg::MEM_BYTES-1];
    logic [5:0] len_reg [0:ufm_pkg::NUM_EP-1];
    logic [5:0] rxptr_reg, txptr_reg;
    logic rx_ok, mcu_buf_wr;
    assign rx_ok = rx_valid_i && ep_on(rx_ep_i, ep_en_reg) && ufm_pkg::ep_is_out(rx_ep_i)
        && !ep_full_o[rx_ep_i] && rxptr_reg < ufm_pkg::ep_size(rx_ep_i);
    assign mcu_buf_wr = dat_wr && cmd_reg == ufm_pkg::CMD_BUFFER
        && idx_reg >= ufm_pkg::BUF_HDR_BYTES && buf_ofs < ufm_pkg::ep_size(sel_ep_reg);

    // Both writers share one array; the full flag blocks only the bus write,
    // so the microcontroller write can land in a buffer the bus is filling.
    always_ff @(posedge core_clk_i) begin
        if (rx_ok) begin
            mem[ufm_pkg::ep_base(rx_ep_i) + {1'b0, rxptr_reg}] <= rx_data_i;
        end
        if (mcu_buf_wr) begin
            mem[ufm_pkg::ep_base(sel_ep_reg) + {1'b0, buf_ofs}] <= md;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (usb_rst) begin
            rxptr_reg <= 6'h00;
        end else if (rx_end_i) begin
            rxptr_reg <= 6'h00;
        end else if (rx_ok) begin
            rxptr_reg <= rxptr_reg + 6'h01;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (usb_rst) begin
            txptr_reg <= 6'h00;
            tx_data_o <= 8'h00;
        end else if (tx_end_i) begin
            txptr_reg <= 6'h00;
        end else if (tx_next_i) begin
            tx_data_o <= mem[ufm_pkg::ep_base(tx_ep_i) + {1'b0, txptr_reg}];
            txptr_reg <= txptr_reg + 6'h01;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (usb_rst) begin
            for (int i = 0; i < ufm_pkg::NUM_EP; i++) begin
                len_reg[i] <= 6'h00;
            end
        end else begin
            if (dat_wr && cmd_reg == ufm_pkg::CMD_BUFFER && idx_reg == 6'h00) begin
                len_reg[sel_ep_reg] <= md[5:0];
            end
            if (rx_end_i && ufm_pkg::ep_is_out(rx_ep_i)) begin
                len_reg[rx_ep_i] <= rxptr_reg;
            end
        end
    end

    // ----------------------------------------
    // Full and interrupt flags (set wins over clear)
    // ----------------------------------------
    logic [5:0] full_set, full_clr, irq_set, irq_clr, irq_reg;
    always_comb begin
        full_set = 6'h00;
        full_clr = 6'h00;
        irq_set = 6'h00;
        irq_clr = 6'h00;
        if (rx_end_i && ufm_pkg::ep_is_out(rx_ep_i) && ep_on(rx_ep_i, ep_en_reg)) begin
            full_set[rx_ep_i] = 1'b1;
            irq_set[rx_ep_i] = 1'b1;
        end
        if (tx_end_i && ep_full_o[tx_ep_i]) begin
            full_clr[tx_ep_i] = 1'b1;
            irq_set[tx_ep_i] = 1'b1;
        end
        if (cmd_wr && md == ufm_pkg::CMD_VALIDATE) begin
            full_set[sel_ep_reg] = 1'b1;
        end
        if (cmd_wr && md == ufm_pkg::CMD_CLEAR_BUF) begin
            full_clr[sel_ep_reg] = 1'b1;
        end
        if (cmd_wr && (md & ufm_pkg::CMD_GROUP_MASK) == ufm_pkg::CMD_SEL_CLR) begin
            irq_clr[md[2:0]] = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (usb_rst) begin
            ep_full_o <= 6'h00;
            irq_reg <= 6'h00;
        end else begin
            ep_full_o <= (ep_full_o & ~full_clr) | full_set;
            irq_reg <= (irq_reg & ~irq_clr) | irq_set;
        end
    end

    // ----------------------------------------
    // Read data and ready handshake
    // ----------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (usb_rst) begin
            pins.dev_data <= 8'h00;
        end else if (dat_rd) begin
            if (cmd_reg == ufm_pkg::CMD_READ_IRQ) begin
                pins.dev_data <= {2'h0, irq_reg};
            end else if (cmd_reg == ufm_pkg::CMD_DEV_STATUS) begin
                pins.dev_data <= {6'h00, bus_suspend_i, addr_en_o};
            end else if (cmd_reg == ufm_pkg::CMD_BUFFER) begin
                if (idx_reg == 6'h00) begin
                    pins.dev_data <= {2'h0, len_reg[sel_ep_reg]};
                end else if (idx_reg == 6'h01) begin
                    pins.dev_data <= 8'h00;
                end else begin
                    pins.dev_data <= mem[ufm_pkg::ep_base(sel_ep_reg) + {1'b0, buf_ofs}];
                end
            end else begin
                pins.dev_data <= {5'h00, ep_stall_o[sel_ep_reg],
                    irq_reg[sel_ep_reg], ep_full_o[sel_ep_reg]};
            end
        end
    end

    // Ready falls with the strobe edge and returns once the strobe is gone
    always_ff @(posedge core_clk_i) begin
        if (usb_rst) begin
            pins.transaction_ready <= 1'b0;
        end else begin
            pins.transaction_ready <= !(wr_s[1] || rd_s[1]);
        end
    end

    // ----------------------------------------
    // Interrupt line with power-down wake hold
    // ----------------------------------------
    logic pend, pend_q;
    logic [11:0] hold_cnt;
    assign pend = |(irq_reg & {{4{ep_en_reg}}, 2'h3});

    always_ff @(posedge core_clk_i) begin
        if (usb_rst) begin
            pend_q <= 1'b0;
            hold_cnt <= 12'h000;
            pins.second_external_irq_n <= 1'b1;
        end else begin
            pend_q <= pend;
            if (pins.suspend_irq_mask && pend && !pend_q) begin
                hold_cnt <= 12'(ufm_pkg::WAKE_HOLD_CYC);
            end else if (hold_cnt != 12'h000) begin
                hold_cnt <= hold_cnt - 12'h001;
            end
            pins.second_external_irq_n <= !(pend || hold_cnt != 12'h000);
        end
    end

    // ----------------------------------------
    // Suspend, wake-up and pull-up pins
    // ----------------------------------------
    logic wake_q;
    always_ff @(posedge core_clk_i) begin
        if (usb_rst) begin
            pins.suspended <= 1'b0;
            pins.bus_active_n <= 1'b1;
            wake_q <= 1'b1;
            wake_req_o <= 1'b0;
            dp_pullup_o <= 1'b0;
            pullup_drive_pin_o <= 1'b0;
        end else begin
            pins.suspended <= bus_suspend_i;
            pins.bus_active_n <= bus_suspend_i;
            wake_q <= pins.remote_wakeup_n;
            wake_req_o <= wake_q && !pins.remote_wakeup_n && bus_suspend_i;
            dp_pullup_o <= pins.internal_pullup_connect;
            pullup_drive_pin_o <= pins.external_pullup_drive;
        end
    end

    // ----------------------------------------
    // Bit clock recovery from the line
    // ----------------------------------------
    // Phase resets on every transition so drift and jitter are absorbed
    logic line_q;
    logic [1:0] phase_reg;
    always_ff @(posedge core_clk_i) begin
        if (usb_rst) begin
            line_q <= 1'b1;
            phase_reg <= 2'h0;
            rx_bit_o <= 1'b1;
            rx_bit_valid_o <= 1'b0;
        end else begin
            line_q <= line_i;
            phase_reg <= (line_i != line_q) ? 2'h0 : phase_reg + 2'h1;
            rx_bit_valid_o <= phase_reg == ufm_pkg::MID_BIT_PHASE;
            rx_bit_o <= line_q;
        end
    end

endmodule // ufm_device

// >>> rtl/ufm_mcu.sv
// Microcontroller end: an AHB-Lite slave whose registers drive the port
// pins and run command/data transactions. Assumes a single-slave bus.
`timescale 1ns/10ps
module ufm_mcu (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    ufm_if.mcu pins
);

    logic [ufm_pkg::CTRL_W-1:0] ctrl_reg;
    logic [7:0] ap_addr;
    logic ap_write;
    ufm_pkg::ufm_host_state_t state;

    // ----------------------------------------
    // Control pins
    // ----------------------------------------
    assign pins.suspend_irq_mask = ctrl_reg[ufm_pkg::CB_MASK];
    assign pins.internal_pullup_connect = ctrl_reg[ufm_pkg::CB_PU_INT];
    assign pins.external_pullup_drive = ctrl_reg[ufm_pkg::CB_PU_EXT];
    assign pins.iface_reset_n = ctrl_reg[ufm_pkg::CB_RST_N];
    assign pins.remote_wakeup_n = !ctrl_reg[ufm_pkg::CB_WAKE];

    // ----------------------------------------
    // Bus and transaction sequencer
    // ----------------------------------------
    // Every access takes at least one wait state so read data is registered
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            state <= ufm_pkg::ST_IDLE;
            ctrl_reg <= ufm_pkg::CTRL_RESET;
            ap_addr <= 8'h00;
            ap_write <= 1'b0;
            hrdata_o <= 32'h0000_0000;
            hreadyout_o <= 1'b1;
            pins.interface_select <= 1'b0;
            pins.command_not_data <= 1'b0;
            pins.write_strobe <= 1'b0;
            pins.read_strobe <= 1'b0;
            pins.mcu_data <= 8'h00;
        end else begin
            case (state)
                ufm_pkg::ST_IDLE: begin
                    if (hsel_i && htrans_i[1] && hready_i) begin
                        ap_addr <= haddr_i[7:0];
                        ap_write <= hwrite_i;
                        hreadyout_o <= 1'b0;
                        state <= ufm_pkg::ST_REG;
                    end
                end
                ufm_pkg::ST_REG: begin
                    hrdata_o <= 32'h0000_0000;
                    if (ap_addr == ufm_pkg::OFS_CMD || ap_addr == ufm_pkg::OFS_DATA) begin
                        pins.command_not_data <= ap_addr == ufm_pkg::OFS_CMD;
                        pins.mcu_data <= hwdata_i[7:0];
                        state <= ufm_pkg::ST_WAIT_RDY;
                    end else begin
                        if (ap_addr == ufm_pkg::OFS_CTRL) begin
                            if (ap_write) begin
                                ctrl_reg <= hwdata_i[ufm_pkg::CTRL_W-1:0];
                            end
                            hrdata_o <= {27'h0, ctrl_reg};
                        end else if (ap_addr == ufm_pkg::OFS_STATUS) begin
                            hrdata_o <= {28'h0, !pins.second_external_irq_n,
                                !pins.bus_active_n, pins.suspended, pins.transaction_ready};
                        end
                        hreadyout_o <= 1'b1;
                        state <= ufm_pkg::ST_IDLE;
                    end
                end
                ufm_pkg::ST_WAIT_RDY: begin
                    pins.interface_select <= 1'b1;
                    if (pins.transaction_ready) begin
                        pins.write_strobe <= ap_write;
                        pins.read_strobe <= !ap_write;
                        state <= ufm_pkg::ST_STROBE;
                    end
                end
                ufm_pkg::ST_STROBE: begin
                    // Ready falling is the device's acknowledge; data is valid then
                    if (!pins.transaction_ready) begin
                        hrdata_o <= {24'h0, pins.dev_data};
                        pins.write_strobe <= 1'b0;
                        pins.read_strobe <= 1'b0;
                        pins.interface_select <= 1'b0;
                        hreadyout_o <= 1'b1;
                        state <= ufm_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state <= ufm_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        hresp_o <= 1'b0;
    end

endmodule // ufm_mcu

// >>> shared/ufm_if.sv
// Port-pin link between the USB function logic and the microcontroller.
// Both ends run on the same core clock; the testbench joins them.
`timescale 1ns/10ps
interface ufm_if;
    logic suspend_irq_mask;
    logic internal_pullup_connect;
    logic external_pullup_drive;
    logic iface_reset_n;
    logic remote_wakeup_n;
    logic command_not_data;
    logic interface_select;
    logic write_strobe;
    logic read_strobe;
    logic [7:0] mcu_data;
    logic transaction_ready;
    logic bus_active_n;
    logic second_external_irq_n;
    logic suspended;
    logic [7:0] dev_data;

    modport dev (
        input suspend_irq_mask, internal_pullup_connect, external_pullup_drive,
        input iface_reset_n, remote_wakeup_n, command_not_data, interface_select,
        input write_strobe, read_strobe, mcu_data,
        output transaction_ready, bus_active_n, second_external_irq_n, suspended,
        output dev_data
    );

    modport mcu (
        output suspend_irq_mask, internal_pullup_connect, external_pullup_drive,
        output iface_reset_n, remote_wakeup_n, command_not_data, interface_select,
        output write_strobe, read_strobe, mcu_data,
        input transaction_ready, bus_active_n, second_external_irq_n, suspended,
        input dev_data
    );
endinterface // ufm_if

// >>> shared/ufm_pkg.sv
// Constants, command codes and helper functions shared by both ends of the
// USB function to microcontroller port link. Assumes a 40 MHz core clock.
// What this block does
// - Four logic endpoints; control has 16-byte buffer
// - Endpoint 1 bulk, 32 bytes, physical 2/3
// - Endpoints 2,3 input-only 8 bytes, physical 4/5
// - Non-control endpoints switchable; control always on
// - Enabled pending endpoints pull interrupt line low
// - Endpoint data kept in on-chip SRAM
// - USB logic runs from the 40 MHz core clock
// - Bit clock recovered by 4x oversampling
// - Controller raises suspend mask around power-down
// - Internal pull-up connect follows its control
// - External pull-up drive follows its control
// - New transaction only while ready shown
// - Bus-active low once suspend is left
// - Interface reset low resets USB logic
// - Suspended flag shown while bus suspended
// - Controller pulls wake-up low for remote wake
// - Command/data select marks command or data
// - Accesses honoured only while interface selected
// - Protocol engine handles packet-level USB protocol
// - Controller enables wake interrupt before power-down
// - Falling interrupt edge wakes; delay holds line low
// - Register access: command cycle then data cycle
package ufm_pkg;

    // ----------------------------------------
    // Clock and timing
    // ----------------------------------------
    localparam int CLK_HZ = 40_000_000;
    localparam int WAKE_HOLD_US = 50;
    localparam int WAKE_HOLD_CYC = WAKE_HOLD_US * (CLK_HZ / 1_000_000);
    localparam int OVERSAMPLE = 4;
    localparam logic [1:0] MID_BIT_PHASE = 2'h2;

    // ----------------------------------------
    // Endpoints and buffer memory
    // ----------------------------------------
    localparam int NUM_EP = 6;
    localparam int MEM_BYTES = 112;
    localparam logic [2:0] FIRST_GATED_EP = 3'h2;

    // ----------------------------------------
    // Command codes
    // ----------------------------------------
    localparam logic [7:0] CMD_SET_ADDR = 8'hD0;
    localparam logic [7:0] CMD_SET_EP_EN = 8'hD8;
    localparam logic [7:0] CMD_READ_IRQ = 8'hF4;
    localparam logic [7:0] CMD_DEV_STATUS = 8'hFE;
    localparam logic [7:0] CMD_BUFFER = 8'hF0;
    localparam logic [7:0] CMD_CLEAR_BUF = 8'hF2;
    localparam logic [7:0] CMD_VALIDATE = 8'hFA;
    localparam logic [7:0] CMD_SEL_CLR = 8'h40;
    localparam logic [7:0] CMD_GROUP_MASK = 8'hF8;
    localparam logic [5:0] BUF_HDR_BYTES = 6'h02;

    // ----------------------------------------
    // Controller register map (AHB-Lite, byte offsets)
    // ----------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_CMD = 8'h08;
    localparam logic [7:0] OFS_DATA = 8'h0C;
    localparam int CTRL_W = 5;
    localparam logic [4:0] CTRL_RESET = 5'h08;
    localparam int CB_MASK = 0;
    localparam int CB_PU_INT = 1;
    localparam int CB_PU_EXT = 2;
    localparam int CB_RST_N = 3;
    localparam int CB_WAKE = 4;

    typedef enum {ST_IDLE, ST_REG, ST_WAIT_RDY, ST_STROBE} ufm_host_state_t;

    function automatic logic [6:0] ep_base(input logic [2:0] ep);
        case (ep)
            3'h0: ep_base = 7'h00;
            3'h1: ep_base = 7'h10;
            3'h2: ep_base = 7'h20;
            3'h3: ep_base = 7'h40;
            3'h4: ep_base = 7'h60;
            default: ep_base = 7'h68;
        endcase
    endfunction

    function automatic logic [5:0] ep_size(input logic [2:0] ep);
        case (ep)
            3'h0, 3'h1: ep_size = 6'h10;
            3'h2, 3'h3: ep_size = 6'h20;
            default: ep_size = 6'h08;
        endcase
    endfunction

    function automatic logic ep_is_out(input logic [2:0] ep);
        ep_is_out = (ep == 3'h0) || (ep == 3'h2);
    endfunction

endpackage

// >>> verif/test_usb_function_mcu_interface.sv
// Self-checking bench joining both ends over the port link.
// Assumes package and interface are compiled first.
`timescale 1ns/10ps
module test_usb_function_mcu_interface;
    logic core_clk_i = 0, reset_i = 1, hsel = 0, hwrite = 0, hready;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic rx_valid = 0, rx_end = 0, bus_susp = 0, addr_en, dp_pu, pu_pin;
    logic [2:0] rx_ep = 3'h0;
    logic [7:0] rx_data = 8'h00;
    logic [6:0] addr;
    int err_count = 0, checks = 0, cyc = 0, i;
    // {ctrl value, {wake_n, rst_n, ext, int, mask}}
    logic [9:0] rows [4] = '{10'h139, 10'h1DE, 10'h308, 10'h17B};
    ufm_if pins_if ();
    ufm_device i_ufm_device (.core_clk_i(core_clk_i), .reset_i(reset_i), .pins(pins_if.dev),
        .line_i(1'b1), .rx_valid_i(rx_valid), .rx_ep_i(rx_ep), .rx_data_i(rx_data),
        .rx_end_i(rx_end), .tx_next_i(1'b0), .tx_ep_i(3'h1), .tx_end_i(1'b0),
        .bus_suspend_i(bus_susp), .tx_data_o(), .rx_bit_o(), .rx_bit_valid_o(),
        .wake_req_o(), .dp_pullup_o(dp_pu), .pullup_drive_pin_o(pu_pin),
        .usb_addr_o(addr), .addr_en_o(addr_en), .ep_full_o(), .ep_stall_o());
    ufm_mcu i_ufm_mcu (.core_clk_i(core_clk_i), .reset_i(reset_i), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
        .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
        .hresp_o(), .pins(pins_if.mcu));
    ufm_monitor i_ufm_monitor (.core_clk_i(core_clk_i), .reset_i(reset_i),
        .suspend_irq_mask(pins_if.suspend_irq_mask), .iface_reset_n(pins_if.iface_reset_n),
        .command_not_data(pins_if.command_not_data),
        .interface_select(pins_if.interface_select), .write_strobe(pins_if.write_strobe),
        .read_strobe(pins_if.read_strobe), .mcu_data(pins_if.mcu_data),
        .transaction_ready(pins_if.transaction_ready), .bus_active_n(pins_if.bus_active_n),
        .second_external_irq_n(pins_if.second_external_irq_n), .suspended(pins_if.suspended));
    // ---
    // Bus and compare tasks
    // ---
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge core_clk_i); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(posedge core_clk_i); while (hready !== 1'b1);
    endtask
    task automatic cmd(input logic [7:0] c, input logic w, input logic [7:0] d);
        bus(1'b1, ufm_pkg::OFS_CMD, c);
        bus(w, ufm_pkg::OFS_DATA, d);
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic end_of_test;
        if (err_count == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial forever #12.5 core_clk_i = ~core_clk_i;
    // Run is well under this; a hang on ready lands here
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            end_of_test;
        end
    end
    initial begin
        repeat (2) @(posedge core_clk_i);
        reset_i <= 1'b0;
        chk("rst_n", 8'h01, pins_if.iface_reset_n);
        for (i = 0; i < 8 && pins_if.transaction_ready !== 1'b1; i++) @(posedge core_clk_i);
        chk("ready", 8'h01, pins_if.transaction_ready);
        foreach (rows[k]) begin
            bus(1'b1, ufm_pkg::OFS_CTRL, {3'h0, rows[k][9:5]});
            bus(1'b0, ufm_pkg::OFS_CTRL, 8'h00);
            chk("ctrl", rows[k][9:5], hrdata[7:0]);
            chk("pins", rows[k][4:0], {pins_if.remote_wakeup_n, pins_if.iface_reset_n,
                pins_if.external_pullup_drive, pins_if.internal_pullup_connect,
                pins_if.suspend_irq_mask});
            chk("pullups", rows[k][7:6], {pu_pin, dp_pu});
        end
        cmd(ufm_pkg::CMD_SET_ADDR, 1'b1, 8'h85);
        for (i = 0; i < 20 && addr_en !== 1'b1; i++) @(posedge core_clk_i);
        chk("addr", 8'h05, addr);
        chk("addr_en", 8'h01, addr_en);
        bus(1'b0, 8'h10, 8'h00);
        chk("unmapped", 8'h00, hrdata[7:0]);
        rx_data <= 8'hA5;
        rx_valid <= 1'b1;
        @(posedge core_clk_i);
        rx_valid <= 1'b0;
        rx_end <= 1'b1;
        @(posedge core_clk_i);
        rx_end <= 1'b0;
        for (i = 0; i < 20 && pins_if.second_external_irq_n !== 1'b0; i++) @(posedge core_clk_i);
        chk("irq_n", 8'h00, pins_if.second_external_irq_n);
        cmd(ufm_pkg::CMD_SEL_CLR, 1'b0, 8'h00);
        chk("ep_state", 8'h01, hrdata[2:0]);
        for (i = 0; i < 2100 && pins_if.second_external_irq_n !== 1'b1; i++)
            @(posedge core_clk_i);
        chk("irq_n", 8'h01, pins_if.second_external_irq_n);
        bus_susp <= 1'b1;
        for (i = 0; i < 40 && {pins_if.suspended, pins_if.bus_active_n} !== 2'h3; i++)
            @(posedge core_clk_i);
        chk("suspended", 8'h01, pins_if.suspended);
        chk("active_n", 8'h01, pins_if.bus_active_n);
        bus_susp <= 1'b0;
        for (i = 0; i < 40 && pins_if.bus_active_n !== 1'b0; i++) @(posedge core_clk_i);
        chk("active_n", 8'h00, pins_if.bus_active_n);
        bus(1'b1, ufm_pkg::OFS_CTRL, 8'h00);
        for (i = 0; i < 10 && addr_en !== 1'b0; i++) @(posedge core_clk_i);
        chk("ready", 8'h00, pins_if.transaction_ready);
        chk("addr_en", 8'h00, addr_en);
        end_of_test;
    end
endmodule // test_usb_function_mcu_interface

// >>> verif/ufm_monitor.sv
// Checker for the port link joining the two ends.
// Assumes the testbench feeds it the link signals beside the interface.
`timescale 1ns/10ps
module ufm_monitor (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic suspend_irq_mask,
    input wire logic iface_reset_n,
    input wire logic command_not_data,
    input wire logic interface_select,
    input wire logic write_strobe,
    input wire logic read_strobe,
    input wire logic [7:0] mcu_data,
    input wire logic transaction_ready,
    input wire logic bus_active_n,
    input wire logic second_external_irq_n,
    input wire logic suspended
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (reset_i);
    // ---
    // Strobe sequences
    // ---
    sequence s_start;
        ($rose(write_strobe) || $rose(read_strobe)) && interface_select;
    endsequence
    sequence s_done;
        $fell(write_strobe) || $fell(read_strobe);
    endsequence
    AST_TAKEN: assert property (s_start |-> ##[1:6] !transaction_ready)
        else $error("strobe not taken");
    AST_RDY_FIRST: assert property (s_start |-> $past(transaction_ready))
        else $error("strobe without ready");
    AST_SEL: assert property ((write_strobe || read_strobe) |-> interface_select)
        else $error("strobe without select");
    AST_STABLE: assert property (write_strobe && $past(write_strobe)
        |-> $stable(command_not_data) && $stable(mcu_data))
        else $error("byte changed under strobe");
    AST_HOLD: assert property (s_done |-> !$past(transaction_ready))
        else $error("strobe dropped before ack");
    AST_BACK: assert property ($fell(interface_select) |-> ##[1:8] transaction_ready)
        else $error("ready did not return");
    AST_IFRST: assert property (!iface_reset_n [*3] |-> !transaction_ready && bus_active_n
        && second_external_irq_n && !suspended)
        else $error("link reset ignored");
    // Short window only; the full hold is far too long to unroll
    AST_WAKE: assert property ($fell(second_external_irq_n) && suspend_irq_mask
        |=> !second_external_irq_n [*8])
        else $error("wake pulse too short");
endmodule // ufm_monitor
